// >>> verification/adcs_conv_model.sv
// Behavioural model of the converter core behind the sequencer.
// Assumes start and abort are one-cycle pulses on clk_in.
`timescale 1ns/100ps

module adcs_conv_model (
   input  wire logic                clk_in,
   input  wire logic                reset_n_in,
   input  wire adcs_pkg::adcs_req_t req_in,
   input  wire logic [5:0]          base_in,
   input  wire logic                slow_in,
   output adcs_pkg::adcs_res_t      res_out
);
   // ==========================================================
   // Conversion timer
   logic [7:0] cnt_q;
   logic       busy_q;
   logic [3:0] chan_q;
   logic [9:0] val;
   logic       done;

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         busy_q <= 1'b0;
         cnt_q  <= 8'h00;
         chan_q <= 4'h0;
      end else if (req_in.start) begin
         busy_q <= 1'b1;
         chan_q <= req_in.chan;
         cnt_q  <= slow_in ? 8'h14 : 8'h03;
      end else if (req_in.abort || (busy_q && cnt_q == 8'h00)) begin
         busy_q <= 1'b0;
      end else if (busy_q) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end

   assign val          = {chan_q, base_in};
   assign done         = busy_q && cnt_q == 8'h00;
   // Outside done the data lines carry the inverted value so stale values cannot match
   assign res_out      = '{done: done, data: done ? val : ~val};
endmodule

// >>> verification/adcs_scan_seq_tb_top.sv
// Self-checking bench for the scan sequencer and its register port.
// Assumes the converter model answers each start after 4 or 21 cycles.
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module adcs_scan_seq_tb_top;
   logic                clk_in = 1'b0;
   logic                reset_n_in = 1'b0;
   adcs_pkg::adcs_bus_t bus = '0;
   adcs_pkg::adcs_res_t res;
   adcs_pkg::adcs_req_t req;
   logic [31:0]         rd_data;
   logic                irq;
   logic [5:0]          base = 6'h15;
   logic                slow = 1'b0;
   int bad_count = 0, n_checks = 0, cyc = 0;
   int st_cnt = 0, ab_cnt = 0, irq_cnt = 0, done_cnt = 0;
   logic [3:0] ch_q[$];
   localparam logic [7:0] THRS [6] = '{8'h08, 8'h09, 8'h09, 8'h08,
                                        8'h20, 8'h20};
   localparam logic [5:0] POLS = 6'b101100;

   always #12.5 clk_in = ~clk_in;

   adcs_scan_seq u_adcs_scan_seq (
      .clk_in                 (clk_in),
      .reset_n_in             (reset_n_in),
      .bus_in                 (bus),
      .conv_res_in            (res),
      .rd_data_out            (rd_data),
      .conv_req_out           (req),
      .conversion_end_irq_out (irq)
   );

   adcs_conv_model u_adcs_conv_model (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .req_in     (req),
      .base_in    (base),
      .slow_in    (slow),
      .res_out    (res)
   );

   // ==========================================================
   // Event monitor and run limit
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         end_of_test();
      end
      if (reset_n_in) begin
         if (req.start) begin
            st_cnt++;
            ch_q.push_back(req.chan);
            `CHK(req.chan <= adcs_pkg::LAST_CH, 1'b1)
         end
         if (req.abort) ab_cnt++;
         if (irq) irq_cnt++;
         if (res.done) done_cnt++;
      end
   end

   // ==========================================================
   // Register port tasks
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_in);
      bus.wr <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_in);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge clk_in);
      bus.rd <= 1'b0;
      #1 `CHK(rd_data, e)
   endtask

   function automatic logic [7:0] ra(input int n);
      return adcs_pkg::ADDR_RES0 + 8'(4 * n);
   endfunction

   function automatic logic [31:0] rx(input int n);
      return {22'h0, 4'(n), base};
   endfunction

   task wait_ev(input int sel, input int n);
      int k;
      k = 0;
      while ((sel == 0 ? done_cnt : sel == 1 ? irq_cnt : st_cnt) < n
             && k < 3000) begin
         @(posedge clk_in);
         k++;
      end
      if (k >= 3000) begin
         bad_count++;
         end_of_test();
      end
   endtask

   task end_of_test();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      int s0, i0, d0, a0, ch;
      logic [7:0] hb;
      repeat (6) @(posedge clk_in);
      reset_n_in <= 1'b1;
      rd(adcs_pkg::ADDR_CTRL, 32'h0);
      rd(adcs_pkg::ADDR_CMP, 32'h0);
      rd(adcs_pkg::ADDR_THR, 32'h0);
      rd(ra(11), 32'h0);
      rd(8'h80, 32'h0);
      wr(adcs_pkg::ADDR_CHSEL, 32'h3);
      wr(adcs_pkg::ADDR_CHSEL, 32'hC);
      rd(adcs_pkg::ADDR_CHSEL, 32'h3);
      // One-shot select, slow core so the active flag can be seen
      slow <= 1'b1;
      wr(adcs_pkg::ADDR_CTRL, 32'h5);
      repeat (3) @(posedge clk_in);
      rd(adcs_pkg::ADDR_CTRL, 32'h85);
      wait_ev(1, 1);
      repeat (40) @(posedge clk_in);
      `CHK(st_cnt, 1)
      `CHK(ch_q[0], 4'h3)
      rd(ra(3), rx(3));
      rd(adcs_pkg::ADDR_CTRL, 32'h5);
      // One-shot scan up to channel 3
      slow <= 1'b0;
      base <= 6'h2A;
      ch_q.delete();
      wr(adcs_pkg::ADDR_CTRL, 32'h7);
      wait_ev(1, 2);
      repeat (30) @(posedge clk_in);
      `CHK(st_cnt, 5)
      for (int n = 0; n < 4; n++) begin
         `CHK(ch_q[n], 4'(n))
         rd(ra(n), rx(n));
      end
      wr(adcs_pkg::ADDR_CTRL, 32'h0);
      // Continuous scan up to channel 2, then enable cleared
      wr(adcs_pkg::ADDR_CHSEL, 32'h2);
      ch_q.delete();
      i0 = irq_cnt;
      d0 = done_cnt;
      wr(adcs_pkg::ADDR_CTRL, 32'h3);
      wait_ev(1, i0 + 2);
      `CHK(irq_cnt - i0, 2)
      `CHK(done_cnt - d0, 6)
      wr(adcs_pkg::ADDR_CTRL, 32'h2);
      repeat (10) @(posedge clk_in);
      for (int n = 0; n < 6; n++) `CHK(ch_q[n], 4'(n % 3))
      s0 = st_cnt;
      repeat (60) @(posedge clk_in);
      `CHK(st_cnt, s0)
      // Continuous select with a compare that always passes
      wr(adcs_pkg::ADDR_CMP, 32'h1);
      wr(adcs_pkg::ADDR_CHSEL, 32'h5);
      ch_q.delete();
      i0 = irq_cnt;
      wr(adcs_pkg::ADDR_CTRL, 32'h1);
      wait_ev(1, i0 + 3);
      wr(adcs_pkg::ADDR_CTRL, 32'h0);
      `CHK(ch_q[2], 4'h5)
      // Continuous scan with a passing compare: interrupt at channel 0
      wr(adcs_pkg::ADDR_CHSEL, 32'h2);
      ch_q.delete();
      i0 = irq_cnt;
      d0 = done_cnt;
      wr(adcs_pkg::ADDR_CTRL, 32'h3);
      wait_ev(1, i0 + 2);
      `CHK(done_cnt - d0, 4)
      wr(adcs_pkg::ADDR_CTRL, 32'h0);
      `CHK(ch_q[3], 4'h0)
      // Compare table: select on channel 0, then scan up to 2
      base <= 6'h20;
      for (int i = 0; i < 6; i++) begin
         ch = i < 4 ? 0 : 2;
         wr(adcs_pkg::ADDR_CTRL, 32'h0);
         wr(adcs_pkg::ADDR_CMP, {30'h0, POLS[i], 1'b1});
         wr(adcs_pkg::ADDR_THR, {24'h0, THRS[i]});
         wr(adcs_pkg::ADDR_CHSEL, 32'(ch));
         d0 = done_cnt;
         i0 = irq_cnt;
         wr(adcs_pkg::ADDR_CTRL, i < 4 ? 32'h5 : 32'h7);
         wait_ev(0, d0 + ch + 1);
         repeat (30) @(posedge clk_in);
         hb = {4'h0, base[5:2]};
         `CHK(irq_cnt - i0, int'(POLS[i] ? hb < THRS[i] : hb >= THRS[i]))
         `CHK(done_cnt - d0, ch + 1)
         rd(ra(0), rx(0));
         rd(ra(ch), rx(ch));
      end
      // Config write in mid-conversion aborts and restarts
      wr(adcs_pkg::ADDR_CTRL, 32'h0);
      wr(adcs_pkg::ADDR_CMP, 32'h0);
      wr(adcs_pkg::ADDR_CHSEL, 32'h1);
      slow <= 1'b1;
      s0 = st_cnt;
      a0 = ab_cnt;
      i0 = irq_cnt;
      wr(adcs_pkg::ADDR_CTRL, 32'h5);
      wait_ev(2, s0 + 1);
      wr(adcs_pkg::ADDR_THR, 32'h33);
      wait_ev(1, i0 + 1);
      `CHK(ab_cnt - a0, 1)
      `CHK(st_cnt - s0, 2)
      rd(ra(1), rx(1));
      end_of_test();
   end
endmodule

// >>> verilog/adcs_pkg.sv
// Constants, modes, states and carrier types for the scan sequencer.
// Assumes a 32-bit plain register port and a 10-bit converter core.
package adcs_pkg;

   // ==========================================================
   // Register map (byte addresses) and field positions
   localparam logic [7:0] ADDR_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_CHSEL = 8'h04;
   localparam logic [7:0] ADDR_CMP   = 8'h08;
   localparam logic [7:0] ADDR_THR   = 8'h0C;
   localparam logic [7:0] ADDR_RES0  = 8'h40;
   localparam int         CTRL_CE    = 0;
   localparam int         CTRL_MODE  = 1;
   localparam int         CTRL_ACT   = 7;
   localparam int         CMP_EN     = 0;
   localparam int         CMP_POL    = 1;
   localparam int         RES_BITS   = 10;
   localparam int         NUM_CH     = 12;
   localparam logic [3:0] LAST_CH    = 4'hB;

   // ==========================================================
   // Values after reset
   localparam logic [3:0]  RST_CHSEL = 4'h0;
   localparam logic [7:0]  RST_THR   = 8'h00;
   localparam logic [9:0]  RST_RES   = 10'h000;
   localparam logic [31:0] RST_RDATA = 32'h0000_0000;

   // ==========================================================
   // Operation modes and sequencer states
   typedef enum logic [1:0] {
      MODE_CONT_SEL = 2'b00,
      MODE_CONT_SCAN = 2'b01,
      MODE_ONE_SEL  = 2'b10,
      MODE_ONE_SCAN = 2'b11
   } adcs_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_WAIT  = 2'b10,
      ST_HALT  = 2'b11
   } adcs_state_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } adcs_bus_t;

   typedef struct packed {
      logic       start;
      logic       abort;
      logic [3:0] chan;
   } adcs_req_t;

   typedef struct packed {
      logic       done;
      logic [9:0] data;
   } adcs_res_t;

endpackage

// >>> verilog/adcs_scan_seq.sv
// Scan sequencer, result registers and threshold compare of a
// 12-channel converter. Assumes the converter core sits on clk_in,
// answers each start with one done pulse, and honours abort.
`timescale 1ns/100ps

// Behaviour
// - Continuous scan converts channel zero up to selected channel, own registers.
// - Continuous scan end of sweep raises interrupt, restarts at zero.
// - One-shot select converts selected channel once, interrupts, then halts.
// - Conversion of channel n always lands in result register n.
// - One-shot scan converts zero to selected once, interrupts, then stops.
// - Without compare, interrupt per select conversion or per scan sweep.
// - Compare, polarity 0: interrupt only if high byte >= threshold.
// - Compare, polarity 1: interrupt only if high byte < threshold.
// - Compare always stores the result, only the interrupt is gated.
// - Compare during scan tests only channel zero result.
// - Compare continuous select keeps reconverting while enable is set.
// - Compare continuous scan restarts at zero unless enable cleared.
// - Compare one-shot modes stop after the single pass.
// - Convert enable at 0 stops all conversion activity.
// - Each result carries 10 bits.
// - Setting convert enable starts conversion, interrupt after storing.
// - Active flag set when a conversion starts.
// - Config register write during conversion aborts and restarts it.
// - Two-bit mode field selects one of four operation modes.
module adcs_scan_seq (
   input  wire logic                clk_in,
   input  wire logic                reset_n_in,
   input  wire adcs_pkg::adcs_bus_t bus_in,
   input  wire adcs_pkg::adcs_res_t conv_res_in,
   output logic [31:0]              rd_data_out,
   output adcs_pkg::adcs_req_t      conv_req_out,
   output logic                     conversion_end_irq_out
);

   // ==========================================================
   // Register file state
   logic                 ce_q, ce_d;
   adcs_pkg::adcs_mode_t mode_q, mode_d;
   logic [3:0]           chsel_q, chsel_d;
   logic                 cmpen_q, cmpen_d;
   logic                 pol_q, pol_d;
   logic [7:0]           thr_q, thr_d;
   logic [9:0]           res_q [adcs_pkg::NUM_CH];
   logic [9:0]           res_d [adcs_pkg::NUM_CH];
   logic [31:0]          rdata_q, rdata_d;

   // ==========================================================
   // Sequencer state
   adcs_pkg::adcs_state_t st_q, st_d;
   logic [3:0]            chan_q, chan_d;
   logic                  act_q, act_d;
   logic                  irq_q, irq_d;
   adcs_pkg::adcs_req_t   req_q, req_d;

   logic       cfg_wr;
   logic       scan;
   logic       oneshot;
   logic       last;
   logic       take;
   logic       pass;
   logic [7:0] hi_byte;
   logic [3:0] res_idx;
   logic       res_hit;

   assign scan    = mode_q[0];
   assign oneshot = mode_q[1];
   assign hi_byte = conv_res_in.data[9:2];
   assign pass    = pol_q ? (hi_byte < thr_q) : (hi_byte >= thr_q);
   assign last    = !scan || (chan_q == chsel_q);
   assign cfg_wr  = bus_in.wr && (bus_in.addr == adcs_pkg::ADDR_CTRL ||
                    bus_in.addr == adcs_pkg::ADDR_CHSEL ||
                    bus_in.addr == adcs_pkg::ADDR_CMP ||
                    bus_in.addr == adcs_pkg::ADDR_THR);
   assign take    = (st_q == adcs_pkg::ST_WAIT) && conv_res_in.done &&
                    ce_q && !cfg_wr;
   assign res_idx = bus_in.addr[5:2];
   assign res_hit = (bus_in.addr[7:6] == 2'b01) &&
                    (bus_in.addr[1:0] == 2'b00) &&
                    (res_idx <= adcs_pkg::LAST_CH);

   // ==========================================================
   // Register file
   always_comb begin
      ce_d    = ce_q;
      mode_d  = mode_q;
      chsel_d = chsel_q;
      cmpen_d = cmpen_q;
      pol_d   = pol_q;
      thr_d   = thr_q;
      res_d   = res_q;
      rdata_d = '0;
      if (bus_in.wr) begin
         if (bus_in.addr == adcs_pkg::ADDR_CTRL) begin
            ce_d   = bus_in.wdata[adcs_pkg::CTRL_CE];
            mode_d = adcs_pkg::adcs_mode_t'(
                     bus_in.wdata[adcs_pkg::CTRL_MODE +: 2]);
         end else if (bus_in.addr == adcs_pkg::ADDR_CHSEL) begin
            if (bus_in.wdata[3:0] <= adcs_pkg::LAST_CH) begin
               chsel_d = bus_in.wdata[3:0];
            end
         end else if (bus_in.addr == adcs_pkg::ADDR_CMP) begin
            cmpen_d = bus_in.wdata[adcs_pkg::CMP_EN];
            pol_d   = bus_in.wdata[adcs_pkg::CMP_POL];
         end else if (bus_in.addr == adcs_pkg::ADDR_THR) begin
            thr_d = bus_in.wdata[7:0];
         end
      end
      if (take) begin
         res_d[chan_q] = conv_res_in.data;
      end
      if (bus_in.rd) begin
         if (bus_in.addr == adcs_pkg::ADDR_CTRL) begin
            rdata_d[adcs_pkg::CTRL_CE]          = ce_q;
            rdata_d[adcs_pkg::CTRL_MODE +: 2]   = mode_q;
            rdata_d[adcs_pkg::CTRL_ACT]         = act_q;
         end else if (bus_in.addr == adcs_pkg::ADDR_CHSEL) begin
            rdata_d[3:0] = chsel_q;
         end else if (bus_in.addr == adcs_pkg::ADDR_CMP) begin
            rdata_d[adcs_pkg::CMP_EN]  = cmpen_q;
            rdata_d[adcs_pkg::CMP_POL] = pol_q;
         end else if (bus_in.addr == adcs_pkg::ADDR_THR) begin
            rdata_d[7:0] = thr_q;
         end else if (res_hit) begin
            rdata_d[9:0] = res_q[res_idx];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         ce_q    <= 1'b0;
         mode_q  <= adcs_pkg::MODE_CONT_SEL;
         chsel_q <= adcs_pkg::RST_CHSEL;
         cmpen_q <= 1'b0;
         pol_q   <= 1'b0;
         thr_q   <= adcs_pkg::RST_THR;
         rdata_q <= adcs_pkg::RST_RDATA;
         for (int i = 0; i < adcs_pkg::NUM_CH; i++) begin
            res_q[i] <= adcs_pkg::RST_RES;
         end
      end else begin
         ce_q    <= ce_d;
         mode_q  <= mode_d;
         chsel_q <= chsel_d;
         cmpen_q <= cmpen_d;
         pol_q   <= pol_d;
         thr_q   <= thr_d;
         rdata_q <= rdata_d;
         res_q   <= res_d;
      end
   end

   // ==========================================================
   // Sequencer
   // A config write never patches a running pass: it drops back to
   // idle, which restarts with the new settings one cycle later.
   always_comb begin
      st_d       = st_q;
      chan_d     = chan_q;
      act_d      = act_q;
      irq_d      = 1'b0;
      req_d      = '0;
      req_d.chan = chan_q;
      case (st_q)
         adcs_pkg::ST_IDLE: begin
            act_d = 1'b0;
            if (ce_q) begin
               st_d   = adcs_pkg::ST_START;
               chan_d = scan ? 4'h0 : chsel_q;
            end
         end
         adcs_pkg::ST_START: begin
            if (!ce_q || cfg_wr) begin
               st_d = adcs_pkg::ST_IDLE;
            end else begin
               req_d.start = 1'b1;
               act_d       = 1'b1;
               st_d        = adcs_pkg::ST_WAIT;
            end
         end
         adcs_pkg::ST_WAIT: begin
            if (!ce_q || cfg_wr) begin
               req_d.abort = 1'b1;
               act_d       = 1'b0;
               st_d        = adcs_pkg::ST_IDLE;
            end else if (take) begin
               if (!cmpen_q) begin
                  irq_d = last;
               end else if (scan) begin
                  irq_d = (chan_q == 4'h0) && pass;
               end else begin
                  irq_d = pass;
               end
               if (last && oneshot) begin
                  st_d  = adcs_pkg::ST_HALT;
                  act_d = 1'b0;
               end else if (last) begin
                  st_d   = adcs_pkg::ST_START;
                  chan_d = scan ? 4'h0 : chsel_q;
               end else begin
                  st_d   = adcs_pkg::ST_START;
                  chan_d = chan_q + 4'h1;
               end
            end
         end
         default: begin
            act_d = 1'b0;
            // Rewriting control re-arms a finished one-shot
            if (!ce_q || cfg_wr) begin
               st_d = adcs_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         st_q   <= adcs_pkg::ST_IDLE;
         chan_q <= 4'h0;
         act_q  <= 1'b0;
         irq_q  <= 1'b0;
         req_q  <= '0;
      end else begin
         st_q   <= st_d;
         chan_q <= chan_d;
         act_q  <= act_d;
         irq_q  <= irq_d;
         req_q  <= req_d;
      end
   end

   assign rd_data_out            = rdata_q;
   assign conv_req_out           = req_q;
   assign conversion_end_irq_out = irq_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_take_last_one;
      take && last && oneshot;
   endsequence
   sequence s_scan_step;
      take && scan && !last;
   endsequence
   sequence s_busy_write;
      (st_q == adcs_pkg::ST_WAIT) && cfg_wr;
   endsequence

   start_sets_active_a : assert property (
      conv_req_out.start |-> act_q && st_q == adcs_pkg::ST_WAIT)
      else $error("start without active flag");
   oneshot_halts_a : assert property (
      s_take_last_one |=> st_q == adcs_pkg::ST_HALT && !act_q
      ##1 !conv_req_out.start)
      else $error("one-shot did not halt");
   // A config write or a cleared enable in the start cycle legally
   // drops back to idle, so only an undisturbed step is followed.
   scan_steps_up_a : assert property (
      s_scan_step ##1 (ce_q && !cfg_wr)
      |-> chan_q == $past(chan_q) + 4'h1
      ##1 conv_req_out.start && conv_req_out.chan == $past(chan_q))
      else $error("scan channel order wrong");
   write_aborts_a : assert property (
      s_busy_write |=> conv_req_out.abort && st_q == adcs_pkg::ST_IDLE)
      else $error("busy write did not abort");
   enable_low_stops_a : assert property (
      !ce_q |=> !conv_req_out.start)
      else $error("start while disabled");
   irq_after_take_a : assert property (
      conversion_end_irq_out |-> $past(take))
      else $error("interrupt without result");
   cmp_ge_gate_a : assert property (
      take && cmpen_q && !pol_q && hi_byte < thr_q
      |=> !conversion_end_irq_out)
      else $error("ge compare let interrupt through");
   cmp_lt_gate_a : assert property (
      take && cmpen_q && pol_q && hi_byte >= thr_q
      |=> !conversion_end_irq_out)
      else $error("lt compare let interrupt through");
   result_lands_a : assert property (
      take |=> res_q[$past(chan_q)] == $past(conv_res_in.data))
      else $error("result not in own register");
   chan_in_range_a : assert property (
      conv_req_out.start |-> conv_req_out.chan <= adcs_pkg::LAST_CH)
      else $error("channel out of range");
   scan_restart_a : assert property (
      take && scan && last && !oneshot |=> chan_q == 4'h0)
      else $error("scan did not restart at zero");

endmodule
